/* File: pkg/fpc_pkg.sv */
// Constants and types for the fan drive channel configuration block.
// How it works
// - Drive full until two speed pulse edges.
// - No pulse after timeout: count 0xffff, fault.
// - Limit 0xffff or 0x0000 suppresses fault bit.
// - Bits [2:0] select the startup timeout.
// - Bit 4 inverts output polarity, default zero.
// - Source 000/001/010 pick one temperature channel.
// - Source 011, the default, drives full speed.
// - Source 100 disables the drive output.
// - Source 101 takes max of local, remote 2.
// - Source 110 takes max of all three.
// - Source 111 manual; duty register becomes writable.
// - Lock bit makes setup register read-only.
// - Count above minimum limit flags slow fan.
package fpc_pkg;
	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] FPC_SETUP_ADDR = 8'h5c;
	localparam logic [7:0] FPC_DUTY_ADDR = 8'h30;
	localparam logic [7:0] FPC_SETUP_RST = 8'h62;
	localparam int FPC_SPIN_LSB = 0;
	localparam int FPC_POL_BIT = 4;
	localparam int FPC_SRC_LSB = 5;
	localparam logic [15:0] FPC_CNT_NONE = 16'hffff;
	localparam logic [15:0] FPC_LIM_ZERO = 16'h0000;
	// ----------------------------------------------------------------
	// Timing: startup timeouts in ms, converted to 50 MHz cycles
	// ----------------------------------------------------------------
	localparam int FPC_CLK_KHZ = 50000;
	localparam int FPC_T1_MS = 100;
	localparam int FPC_T2_MS = 250;
	localparam int FPC_T3_MS = 400;
	localparam int FPC_T4_MS = 667;
	localparam int FPC_T5_MS = 1000;
	localparam int FPC_T6_MS = 2000;
	localparam int FPC_T7_MS = 4000;
	localparam int FPC_MS_CYC = FPC_CLK_KHZ;
	localparam int FPC_EDGES_NEEDED = 2;
	// Control source selection.
	typedef enum logic [2:0] {
		FPC_SRC_REM1 = 3'b000,
		FPC_SRC_LOCAL = 3'b001,
		FPC_SRC_REM2 = 3'b010,
		FPC_SRC_FULL = 3'b011,
		FPC_SRC_OFF = 3'b100,
		FPC_SRC_MAX2 = 3'b101,
		FPC_SRC_MAX3 = 3'b110,
		FPC_SRC_MANUAL = 3'b111
	} fpc_src_e;
	// Spin-up state.
	typedef enum logic [1:0] {
		FPC_ST_IDLE = 2'b00,
		FPC_ST_SPIN = 2'b01,
		FPC_ST_RUN = 2'b10
	} fpc_st_e;
endpackage

/* File: src/fpc_channel.sv */
// Fan drive channel: setup register, source select, spin-up, fault.
`timescale 1ns/100ps
module fpc_channel
	import fpc_pkg::*;
#(
	parameter int DW = 8,
	parameter int MS_CYC = FPC_MS_CYC
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Register port.
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] setup_rdata,
	output logic [DW-1:0] duty_rdata,
	// Configuration lock from configuration register 1.
	input wire logic cfg_lock,
	// Computed duties per temperature channel.
	input wire logic [DW-1:0] duty_rem1,
	input wire logic [DW-1:0] duty_local,
	input wire logic [DW-1:0] duty_rem2,
	// Fan speed measurement.
	input wire logic fan_speed_pulse,
	input wire logic meas_done,
	input wire logic [15:0] meas_count,
	input wire logic [15:0] fan_min_limit,
	// Results.
	output logic [15:0] speed_count,
	output logic fan_fault,
	output logic [DW-1:0] duty_out,
	output logic output_polarity_invert,
	output logic fan_drive_full
);
	// ----------------------------------------------------------------
	// Setup and manual duty registers
	// ----------------------------------------------------------------
	logic [7:0] setup_q, setup_d;
	logic [DW-1:0] man_q, man_d;
	fpc_src_e src;
	logic flip;
	assign src = fpc_src_e'(setup_q[FPC_SRC_LSB +: 3]);
	assign flip = setup_q[FPC_POL_BIT];
	// Writes: setup blocked by lock, duty only in manual mode.
	always_comb
	begin
		setup_d = setup_q;
		man_d = man_q;
		if (reg_wr && reg_addr == FPC_SETUP_ADDR && !cfg_lock)
			setup_d = reg_wdata;
		if (reg_wr && reg_addr == FPC_DUTY_ADDR && src == FPC_SRC_MANUAL)
			man_d = reg_wdata[DW-1:0];
	end
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			setup_q <= FPC_SETUP_RST;
			man_q <= '0;
		end
		else
		begin
			setup_q <= setup_d;
			man_q <= man_d;
		end
	end
	// ----------------------------------------------------------------
	// Pulse edge detect and spin-up
	// ----------------------------------------------------------------
	logic pls_q, pls_d;
	logic run_q, run_d;
	logic spinning, timed_out, pulse_rise, start;
	logic spin_nrst;
	assign pulse_rise = fan_speed_pulse && !pls_q;
	// A spin-up starts whenever the channel leaves the disabled state.
	assign start = run_d && !run_q;
	// The sequencer sits in reset while disabled, so that a stale spin or
	// timeout cannot leak into the next enable.
	assign spin_nrst = nrst && run_d;
	always_comb
	begin
		pls_d = fan_speed_pulse;
		run_d = (src != FPC_SRC_OFF);
	end
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			pls_q <= 1'b1; // Idle level of the pulled-up line.
			run_q <= 1'b0;
		end
		else
		begin
			pls_q <= pls_d;
			run_q <= run_d;
		end
	end
	fpc_spinup #(.MS_CYC(MS_CYC)) u_spin (
		.sys_clk(sys_clk),
		.nrst(spin_nrst),
		.start(start),
		.spin_sel(setup_q[FPC_SPIN_LSB +: 3]),
		.pulse_rise(pulse_rise),
		.spinning(spinning),
		.timed_out(timed_out)
	);
	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	logic [DW-1:0] sel_duty, max2;
	logic sel_full;
	assign max2 = (duty_local > duty_rem2) ? duty_local : duty_rem2;
	always_comb
	begin
		sel_full = 1'b0;
		case (src)
			FPC_SRC_REM1: sel_duty = duty_rem1;
			FPC_SRC_LOCAL: sel_duty = duty_local;
			FPC_SRC_REM2: sel_duty = duty_rem2;
			FPC_SRC_FULL:
			begin
				sel_duty = '1;
				sel_full = 1'b1;
			end
			FPC_SRC_OFF: sel_duty = '0;
			FPC_SRC_MAX2: sel_duty = max2;
			FPC_SRC_MAX3:
				sel_duty = (duty_rem1 > max2) ? duty_rem1 : max2;
			FPC_SRC_MANUAL: sel_duty = man_q;
			default: sel_duty = '0;
		endcase
	end
	// ----------------------------------------------------------------
	// Outputs, speed count and fault
	// ----------------------------------------------------------------
	logic [DW-1:0] duty_q, duty_d;
	logic full_q, full_d, flip_q, flip_d, flt_q, flt_d, chk_q, chk_d;
	logic [15:0] cnt_q, cnt_d;
	logic lim_off;
	assign lim_off = (fan_min_limit == FPC_CNT_NONE)
		|| (fan_min_limit == FPC_LIM_ZERO);
	always_comb
	begin
		duty_d = spinning ? '1 : sel_duty;
		full_d = spinning || sel_full;
		flip_d = flip;
		cnt_d = cnt_q;
		flt_d = flt_q;
		chk_d = chk_q;
		// A disabled channel overrides spin-up and sits at 0% duty.
		if (src == FPC_SRC_OFF)
		begin
			duty_d = '0;
			full_d = 1'b0;
		end
		if (meas_done)
		begin
			chk_d = 1'b0;
			if (chk_q && meas_count == FPC_CNT_NONE)
			begin
				cnt_d = FPC_CNT_NONE;
				if (!lim_off)
					flt_d = 1'b1;
			end
			else
			begin
				cnt_d = meas_count;
				if (!lim_off && meas_count > fan_min_limit)
					flt_d = 1'b1;
			end
		end
		// A timeout beside a measurement still arms the next one.
		if (timed_out)
			chk_d = 1'b1;
		if (src == FPC_SRC_OFF)
			flt_d = 1'b0;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			duty_q <= '0;
			full_q <= 1'b0;
			flip_q <= 1'b0;
			cnt_q <= FPC_CNT_NONE;
			flt_q <= 1'b0;
			chk_q <= 1'b0;
		end
		else
		begin
			duty_q <= duty_d;
			full_q <= full_d;
			flip_q <= flip_d;
			cnt_q <= cnt_d;
			flt_q <= flt_d;
			chk_q <= chk_d;
		end
	end
	assign setup_rdata = setup_q;
	assign duty_rdata = man_q;
	assign duty_out = duty_q;
	assign fan_drive_full = full_q;
	assign output_polarity_invert = flip_q;
	assign speed_count = cnt_q;
	assign fan_fault = flt_q;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Spin-up drives full and starts on every enable.
	a_spin_full: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(spinning && src != FPC_SRC_OFF) |=> fan_drive_full)
		else $error("not full in spin");
	a_spin_duty: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(spinning && src != FPC_SRC_OFF) |=> duty_out == '1)
		else $error("spin duty not full");
	a_start_spin: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		start |=> spinning)
		else $error("enable without spin-up");
	// A disabled channel is quiet: no duty, no full flag, no spin.
	a_off_zero: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		src == FPC_SRC_OFF |=> duty_out == '0)
		else $error("disabled not zero");
	a_off_nofull: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		src == FPC_SRC_OFF |=> !fan_drive_full)
		else $error("disabled but full");
	a_off_idle: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		src == FPC_SRC_OFF |=> !spinning)
		else $error("disabled but spinning");
	a_off_nofault: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		src == FPC_SRC_OFF |=> !fan_fault)
		else $error("disabled but faulted");
	// Each control source reaches the duty output one cycle later.
	a_full_mode: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		src == FPC_SRC_FULL |=> duty_out == '1)
		else $error("full mode not full");
	a_rem1_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_REM1 && !spinning) |=> duty_out == $past(duty_rem1))
		else $error("remote 1 not selected");
	a_local_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_LOCAL && !spinning) |=> duty_out == $past(duty_local))
		else $error("local not selected");
	a_rem2_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_REM2 && !spinning) |=> duty_out == $past(duty_rem2))
		else $error("remote 2 not selected");
	a_max2_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_MAX2 && !spinning) |=>
		duty_out >= $past(duty_local) && duty_out >= $past(duty_rem2))
		else $error("max2 low");
	a_max3_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_MAX3 && !spinning) |=> duty_out >= $past(duty_rem1))
		else $error("max3 low");
	a_max3_top: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_MAX3 && !spinning) |=>
		duty_out >= $past(duty_local) && duty_out >= $past(duty_rem2))
		else $error("max3 below local or remote 2");
	a_manual_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(src == FPC_SRC_MANUAL && !spinning) |=> duty_out == $past(man_q))
		else $error("manual duty not used");
	// Register writes obey the manual mode and the lock.
	a_duty_refuse: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && reg_addr == FPC_DUTY_ADDR && src != FPC_SRC_MANUAL)
		|=> $stable(man_q))
		else $error("duty written outside manual");
	a_lock_holds: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		cfg_lock |=> $stable(setup_q))
		else $error("locked write");
	a_setup_write: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && reg_addr == FPC_SETUP_ADDR && !cfg_lock)
		|=> setup_q == $past(reg_wdata))
		else $error("unlocked write lost");
	// The exported polarity bit follows the setup register.
	a_pol_follow: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		##1 output_polarity_invert == $past(flip))
		else $error("polarity lag");
	// Speed count and fault flag after each measurement.
	a_tmo_arms: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		timed_out |=> chk_q)
		else $error("timeout did not arm check");
	a_count_load: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		meas_done |=> speed_count == $past(meas_count))
		else $error("speed count not loaded");
	a_nostart_fault: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(meas_done && chk_q && meas_count == FPC_CNT_NONE
		&& !lim_off && src != FPC_SRC_OFF) |=> fan_fault)
		else $error("failed start not flagged");
	a_lim_nofault: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(lim_off && !fan_fault) |=> !fan_fault)
		else $error("fault with limit off");
	a_slow_fault: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(meas_done && !lim_off && meas_count > fan_min_limit
		&& src != FPC_SRC_OFF) |=> fan_fault)
		else $error("slow fan missed");
	// Main scenarios that the bench is meant to reach.
	c_spin: cover property (@(posedge sys_clk) spinning ##1 !spinning);
	c_tmo: cover property (@(posedge sys_clk) timed_out);
	c_fault: cover property (@(posedge sys_clk) $rose(fan_fault));
	c_manual: cover property (@(posedge sys_clk)
		src == FPC_SRC_MANUAL && !spinning);
	c_lock_refused: cover property (@(posedge sys_clk)
		reg_wr && cfg_lock && reg_addr == FPC_SETUP_ADDR);
endmodule

/* File: src/fpc_spinup.sv */
// Spin-up sequencer: full drive until two pulse edges or timeout.
`timescale 1ns/100ps
module fpc_spinup
	import fpc_pkg::*;
#(
	parameter int MS_CYC = FPC_MS_CYC
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Control.
	input wire logic start,
	input wire logic [2:0] spin_sel,
	input wire logic pulse_rise,
	// Status.
	output logic spinning,
	output logic timed_out
);
	// ----------------------------------------------------------------
	// Timeout selection
	// ----------------------------------------------------------------
	logic [11:0] tmo_ms;
	always_comb
	begin
		case (spin_sel)
			3'b001: tmo_ms = 12'(FPC_T1_MS);
			3'b010: tmo_ms = 12'(FPC_T2_MS);
			3'b011: tmo_ms = 12'(FPC_T3_MS);
			3'b100: tmo_ms = 12'(FPC_T4_MS);
			3'b101: tmo_ms = 12'(FPC_T5_MS);
			3'b110: tmo_ms = 12'(FPC_T6_MS);
			3'b111: tmo_ms = 12'(FPC_T7_MS);
			default: tmo_ms = 12'h000;
		endcase
	end
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	fpc_st_e st_q, st_d;
	logic [1:0] edg_q, edg_d;
	logic [31:0] cyc_q, cyc_d;
	logic [11:0] ms_q, ms_d;
	logic to_q, to_d;
	// Next state: count edges and milliseconds while spinning.
	always_comb
	begin
		st_d = st_q;
		edg_d = edg_q;
		cyc_d = cyc_q;
		ms_d = ms_q;
		to_d = 1'b0;
		case (st_q)
			FPC_ST_IDLE:
			begin
				if (start)
				begin
					st_d = FPC_ST_SPIN;
					edg_d = 2'h0;
					cyc_d = 32'h0;
					ms_d = 12'h000;
				end
			end
			FPC_ST_SPIN:
			begin
				if (pulse_rise)
					edg_d = edg_q + 2'h1;
				if (pulse_rise && edg_q == 2'(FPC_EDGES_NEEDED - 1))
					st_d = FPC_ST_RUN;
				else if (tmo_ms != 12'h000 && ms_q >= tmo_ms)
				begin
					st_d = FPC_ST_RUN;
					to_d = 1'b1;
				end
				else if (cyc_q == 32'(MS_CYC - 1))
				begin
					cyc_d = 32'h0;
					ms_d = ms_q + 12'h001;
				end
				else
					cyc_d = cyc_q + 32'h1;
			end
			FPC_ST_RUN:
			begin
				if (start)
					st_d = FPC_ST_IDLE;
			end
			default: st_d = FPC_ST_IDLE;
		endcase
	end
	// Register stage.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			st_q <= FPC_ST_IDLE;
			edg_q <= 2'h0;
			cyc_q <= 32'h0;
			ms_q <= 12'h000;
			to_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			edg_q <= edg_d;
			cyc_q <= cyc_d;
			ms_q <= ms_d;
			to_q <= to_d;
		end
	end
	assign spinning = (st_q == FPC_ST_SPIN);
	assign timed_out = to_q;
	// Timeout pulse only follows a spin phase.
	a_tmo_after_spin: assert property (@(posedge sys_clk) disable iff (!nrst)
		timed_out |-> $past(spinning)) else $error("timeout without spin");
endmodule

/* File: tb/fpc_channel_tb.sv */
// Self-checking bench for the fan drive channel configuration block.
`timescale 1ns/100ps
module fpc_channel_tb;
	import fpc_pkg::*;
	typedef struct packed
	{
		logic [7:0] setup;
		logic [7:0] duty;
		logic full;
		logic pol;
		logic dk;
	} fpc_row_s;
	logic sys_clk, nrst, reg_wr, cfg_lock, meas_done, fan_on, fan_speed_pulse;
	logic [7:0] reg_addr, reg_wdata, setup_rdata, duty_rdata, duty_out;
	logic [7:0] duty_rem1, duty_local, duty_rem2;
	logic [15:0] meas_count, fan_min_limit, speed_count;
	logic fan_fault, output_polarity_invert, fan_drive_full;
	int err_count = 0;
	int check_count = 0;
	int rises = 0;
	int n;
	logic [15:0] lims [3] = '{16'h1000, 16'hffff, 16'h0000};
	logic fexp [3] = '{1'b1, 1'b0, 1'b0};
	// Source rows: the duty column is skipped where dk is clear.
	fpc_row_s rows [8] = '{
		'{8'h02, 8'hc0, 1'b0, 1'b0, 1'b1}, '{8'h22, 8'h90, 1'b0, 1'b0, 1'b1},
		'{8'h42, 8'h40, 1'b0, 1'b0, 1'b1}, '{8'h62, 8'hff, 1'b1, 1'b0, 1'b1},
		'{8'h82, 8'h00, 1'b0, 1'b0, 1'b1}, '{8'ha2, 8'h90, 1'b0, 1'b0, 1'b1},
		'{8'hc2, 8'hc0, 1'b0, 1'b0, 1'b1}, '{8'h92, 8'h00, 1'b0, 1'b1, 1'b1}};

	fpc_channel #(.DW(8), .MS_CYC(10)) fpc_channel_i (.sys_clk(sys_clk),
		.nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .setup_rdata(setup_rdata),
		.duty_rdata(duty_rdata), .cfg_lock(cfg_lock), .duty_rem1(duty_rem1),
		.duty_local(duty_local), .duty_rem2(duty_rem2),
		.fan_speed_pulse(fan_speed_pulse), .meas_done(meas_done),
		.meas_count(meas_count), .fan_min_limit(fan_min_limit),
		.speed_count(speed_count), .fan_fault(fan_fault), .duty_out(duty_out),
		.output_polarity_invert(output_polarity_invert),
		.fan_drive_full(fan_drive_full));
	fpc_fan_model fpc_fan_model_i (.sys_clk(sys_clk), .nrst(nrst),
		.spin(fan_on), .fan_speed_pulse(fan_speed_pulse));

	// Clock at 50 MHz.
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Count speed pulse rises seen by the block.
	always @(posedge fan_speed_pulse) rises++;

	// Verdict and end of run.
	task automatic tally_and_finish;
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Compare a settled output with its expected value.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Wait cycles, then step past the edge so outputs are settled.
	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	// One register write cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// One finished speed measurement.
	task automatic meas(input logic [15:0] c);
		@(posedge sys_clk);
		meas_done <= 1'b1;
		meas_count <= c;
		@(posedge sys_clk);
		meas_done <= 1'b0;
	endtask

	// Main sequence.
	initial
	begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		cfg_lock = 1'b0;
		meas_done = 1'b0;
		meas_count = 16'h0000;
		fan_min_limit = 16'h0100;
		fan_on = 1'b1;
		duty_rem1 = 8'hc0;
		duty_local = 8'h90;
		duty_rem2 = 8'h40;
		cyc(2);
		chk(setup_rdata, FPC_SETUP_RST);
		chk(speed_count, 16'hffff);
		chk(fan_fault, 1'b0);
		chk(output_polarity_invert, 1'b0);
		@(posedge sys_clk) nrst <= 1'b1;
		cyc(3);
		wr(FPC_DUTY_ADDR, 8'h5a);
		cyc(3);
		chk(duty_rdata, 8'h00);
		foreach (rows[i])
		begin
			wr(FPC_SETUP_ADDR, rows[i].setup);
			cyc(100);
			chk(setup_rdata, rows[i].setup);
			if (rows[i].dk)
				chk(duty_out, rows[i].duty);
			chk(fan_drive_full, rows[i].full);
			chk(output_polarity_invert, rows[i].pol);
		end
		wr(FPC_SETUP_ADDR, 8'he2);
		wr(FPC_DUTY_ADDR, 8'h5a);
		// Leaving the disabled row starts a spin-up; let it finish first.
		cyc(100);
		chk(duty_rdata, 8'h5a);
		chk(duty_out, 8'h5a);
		@(posedge sys_clk) cfg_lock <= 1'b1;
		wr(FPC_SETUP_ADDR, 8'h02);
		cyc(3);
		chk(setup_rdata, 8'he2);
		@(posedge sys_clk) cfg_lock <= 1'b0;
		// Stalled start, then a fan that begins turning.
		wr(FPC_SETUP_ADDR, 8'h82);
		@(posedge sys_clk) fan_on <= 1'b0;
		wr(FPC_SETUP_ADDR, 8'h02);
		cyc(300);
		chk(fan_drive_full, 1'b1);
		@(posedge sys_clk) fan_on <= 1'b1;
		rises = 0;
		n = 0;
		while (fan_drive_full !== 1'b0 && n < 400)
		begin
			cyc(1);
			n++;
		end
		if (n == 400)
		begin
			err_count++;
			$display("Error %0t: spin-up never ended", $time);
			tally_and_finish();
		end
		chk(rises >= 2, 1'b1);
		// Start-up timeout with no pulse, for each kind of limit.
		for (int k = 0; k < 3; k++)
		begin
			wr(FPC_SETUP_ADDR, 8'h81);
			@(posedge sys_clk)
			begin
				fan_on <= 1'b0;
				fan_min_limit <= lims[k];
			end
			wr(FPC_SETUP_ADDR, 8'h01);
			cyc(950);
			chk(fan_drive_full, 1'b1);
			cyc(150);
			meas(16'hffff);
			cyc(3);
			chk(speed_count, 16'hffff);
			chk(fan_fault, fexp[k]);
		end
		// Slow fan against the minimum limit, at and one above it.
		wr(FPC_SETUP_ADDR, 8'h82);
		@(posedge sys_clk)
		begin
			fan_on <= 1'b1;
			fan_min_limit <= 16'h0100;
		end
		wr(FPC_SETUP_ADDR, 8'h02);
		cyc(200);
		meas(16'h0100);
		cyc(3);
		chk(fan_fault, 1'b0);
		meas(16'h0101);
		cyc(3);
		chk(speed_count, 16'h0101);
		chk(fan_fault, 1'b1);
		// Reset in mid-run restores the defaults and restarts spin-up.
		@(posedge sys_clk) nrst <= 1'b0;
		cyc(2);
		chk(setup_rdata, FPC_SETUP_RST);
		chk(fan_fault, 1'b0);
		chk(speed_count, 16'hffff);
		@(posedge sys_clk) nrst <= 1'b1;
		cyc(2);
		chk(fan_drive_full, 1'b1);
		tally_and_finish();
	end
endmodule

/* File: tb/fpc_fan_model.sv */
// Behavioural fan: speed pulse train while spinning, still otherwise.
`timescale 1ns/100ps
module fpc_fan_model
#(
	parameter int PER = 20
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Fan supply state from the bench.
	input wire logic spin,
	// Speed pulse toward the block.
	output logic fan_speed_pulse
);
	int cnt_q;
	// A stalled fan leaves the open-collector line at its pull-up level.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst || !spin)
		begin
			cnt_q <= 0;
			fan_speed_pulse <= 1'b1;
		end
		else
		begin
			cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
			fan_speed_pulse <= (cnt_q < PER / 2);
		end
	end
endmodule
